/* File: logic/flash_cmd_dev.sv */
`timescale 1ns/100ps
module flash_cmd_dev
  import fvc_pkg::*;
#(
  parameter logic [23:0] FLASH_BYTES = FLASH_BYTES_DEF,
  parameter logic [23:0] VERSION = VERSION_DEF
) (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RSTN,
  // serial link
  input wire logic I_LINK_SCK,
  input wire logic I_LINK_SI,
  output logic O_LINK_SO,
  output logic O_HANDSHAKE_LINE,
  // flash read port, one cycle latency
  output logic [ADDR_W-1:0] O_FLASH_ADDR,
  input wire logic [7:0] I_FLASH_RDATA
);
  typedef enum logic [2:0] {S_RX, S_EVAL, S_SEND, S_DRAIN, S_CALC} state_e;

  // =========================================================
  // helpers
  function automatic logic [7:0] eval_code(input logic bad, input logic [7:0] len,
                                           input cmd_frame_s f, input logic [7:0] acc);
    logic ok_len;
    logic ok_prm;
    ok_len = (f.cmd == CMD_VERSION && len == LEN_VERSION) || (f.cmd == CMD_CHECKSUM && len == LEN_CHECKSUM);
    ok_prm = (f.cmd != CMD_CHECKSUM) || (f.start[BLOCK_BITS-1:0] == '0 && f.stop[BLOCK_BITS-1:0] == '1
              && f.stop >= f.start && f.stop < FLASH_BYTES);
    if (bad || !ok_len) eval_code = ST_NACK;
    else if (acc != 8'h00) eval_code = ST_SUM_ERR;
    else if (!ok_prm) eval_code = ST_PARAM_ERR;
    else eval_code = ST_ACK;
  endfunction

  function automatic logic [7:0] frame_byte(input logic [3:0] idx, input logic [7:0] plen,
                                            input logic [23:0] pay);
    logic [7:0] sum;
    sum = 8'h00 - plen - pay[23:16] - pay[15:8] - pay[7:0];
    if (idx == 4'h0) frame_byte = STX_BYTE;
    else if (idx == 4'h1) frame_byte = plen;
    else if (idx == 4'h2) frame_byte = pay[23:16];
    else if ({4'h0, idx} < plen + 8'h02) frame_byte = (idx == 4'h3) ? pay[15:8] : pay[7:0];
    else if ({4'h0, idx} == plen + 8'h02) frame_byte = sum;
    else frame_byte = ETX_BYTE;
  endfunction

  // =========================================================
  // link sampling
  logic sck_s1_q, sck_s2_q, sck_s3_q, si_s1_q, si_s2_q;
  logic rise, fall, byte_done;
  logic [2:0] bitcnt_q;
  logic [7:0] rxsh_q, rx_byte, txsh_q;
  logic tx_loaded_q;

  // two flops before use; edges seen on the second stage only
  // no reset: the chain fills with the idle pin level, so no false edge follows release
  // limitation: reset must last three clocks or more for the chain to settle
  always_ff @(posedge I_CLK) begin
    {sck_s1_q, sck_s2_q, sck_s3_q} <= {I_LINK_SCK, sck_s1_q, sck_s2_q};
    {si_s1_q, si_s2_q} <= {I_LINK_SI, si_s1_q};
  end

  assign rise = sck_s2_q && !sck_s3_q;
  assign fall = !sck_s2_q && sck_s3_q;
  assign rx_byte = {rxsh_q[6:0], si_s2_q};
  assign byte_done = rise && (bitcnt_q == 3'h7);

  // receive shifter, msb first, sampled on rising link edge
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      bitcnt_q <= 3'h0;
      rxsh_q <= 8'h00;
    end else if (rise) begin
      bitcnt_q <= bitcnt_q + 3'h1;
      rxsh_q <= rx_byte;
    end
  end

  // =========================================================
  // response buffer between frame builder and shifter
  logic [7:0] push_data, buf_data;
  logic push_valid, push_ready, buf_valid, pop;

  assign pop = buf_valid && (byte_done || (!tx_loaded_q && bitcnt_q == 3'h0));

  byte_buf #(.W(8), .D(BUF_DEPTH)) u_buf (
    .i_clk(I_CLK),
    .i_rst_n(I_RSTN),
    .i_data(push_data),
    .i_valid(push_valid),
    .o_ready(push_ready),
    .o_data(buf_data),
    .o_valid(buf_valid),
    .i_ready(pop)
  );

  // transmit shifter: loaded before first rising edge, shifts on falling
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      txsh_q <= IDLE_FILL;
      tx_loaded_q <= 1'b0;
    end else if (byte_done) begin
      txsh_q <= buf_valid ? buf_data : IDLE_FILL;
      tx_loaded_q <= buf_valid;
    end else if (pop) begin
      txsh_q <= buf_data;
      tx_loaded_q <= 1'b1;
    end else if (fall && bitcnt_q != 3'h0) begin
      txsh_q <= {txsh_q[6:0], 1'b1};
    end
  end

  // =========================================================
  // command frame parser and sequencer
  state_e state_q;
  logic [3:0] rcnt_q, idx_q;
  logic [7:0] len_q, acc_q, plen_q, code;
  logic [7:0] body_q [7];
  logic bad_q, data_next_q, phase_q, frame_done;
  logic [23:0] pay_q;
  logic [15:0] cs_q, cs_next;
  cmd_frame_s frm;

  assign frm = '{cmd: body_q[0], start: {body_q[1], body_q[2], body_q[3]},
                 stop: {body_q[4], body_q[5], body_q[6]}};
  assign code = eval_code(bad_q, len_q, frm, acc_q);
  assign push_valid = (state_q == S_SEND);
  assign push_data = frame_byte(idx_q, plen_q, pay_q);
  assign cs_next = cs_q - {8'h00, I_FLASH_RDATA};
  assign frame_done = byte_done && state_q == S_RX && rcnt_q != 4'h0
                      && ((rcnt_q == 4'h1 && (rx_byte == 8'h00 || rx_byte > LEN_MAX))
                          || {4'h0, rcnt_q} == len_q + 8'h03);

  // byte collection: bad length or missing end byte flags the frame
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      rcnt_q <= 4'h0;
      len_q <= 8'h00;
      acc_q <= 8'h00;
      bad_q <= 1'b0;
    end else if (state_q == S_EVAL) begin
      rcnt_q <= 4'h0;
    end else if (byte_done && state_q == S_RX) begin
      if (rcnt_q == 4'h0) begin
        bad_q <= 1'b0;
        if (rx_byte == SOH_BYTE) rcnt_q <= 4'h1;
      end else if (rcnt_q == 4'h1) begin
        len_q <= rx_byte;
        acc_q <= rx_byte;
        rcnt_q <= 4'h2;
        if (rx_byte == 8'h00 || rx_byte > LEN_MAX) bad_q <= 1'b1;
      end else if ({4'h0, rcnt_q} == len_q + 8'h03) begin
        if (rx_byte != ETX_BYTE) bad_q <= 1'b1;
      end else begin
        acc_q <= acc_q + rx_byte;
        rcnt_q <= rcnt_q + 4'h1;
        if ({4'h0, rcnt_q} <= len_q + 8'h01) body_q[rcnt_q[2:0] - 3'h2] <= rx_byte;
      end
    end
  end

  // frame sequencing; waits on the buffer so a stalled link loses nothing
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      state_q <= S_RX;
      idx_q <= 4'h0;
      plen_q <= STAT_PLEN;
      pay_q <= 24'h000000;
      data_next_q <= 1'b0;
      phase_q <= 1'b0;
      cs_q <= 16'h0000;
      O_FLASH_ADDR <= '0;
    end else begin
      case (state_q)
        S_RX: begin
          if (frame_done) state_q <= S_EVAL;
        end
        S_EVAL: begin
          pay_q <= {code, 16'h0000};
          plen_q <= STAT_PLEN;
          idx_q <= 4'h0;
          data_next_q <= (code == ST_ACK);
          state_q <= S_SEND;
        end
        S_SEND: begin
          if (push_ready) begin
            idx_q <= idx_q + 4'h1;
            if ({4'h0, idx_q} == plen_q + 8'h03) state_q <= S_DRAIN;
          end
        end
        S_DRAIN: begin
          if (!buf_valid && !tx_loaded_q && bitcnt_q == 3'h0) begin
            data_next_q <= 1'b0;
            state_q <= data_next_q ? S_CALC : S_RX;
            O_FLASH_ADDR <= frm.start;
            cs_q <= 16'h0000;
            phase_q <= 1'b0;
          end
        end
        S_CALC: begin
          idx_q <= 4'h0;
          if (frm.cmd == CMD_VERSION) begin
            pay_q <= VERSION;
            plen_q <= VER_PLEN;
            state_q <= S_SEND;
          end else if (!phase_q) begin
            phase_q <= 1'b1; // address settles, data next cycle
          end else begin
            cs_q <= cs_next;
            phase_q <= 1'b0;
            if (O_FLASH_ADDR == frm.stop) begin
              pay_q <= {cs_next, 8'h00}; // upper byte first
              plen_q <= SUM_PLEN;
              state_q <= S_SEND;
            end else begin
              O_FLASH_ADDR <= O_FLASH_ADDR + 24'h000001;
            end
          end
        end
        default: state_q <= S_RX;
      endcase
    end
  end

  // ready only while listening or once a response byte sits in the shifter
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      O_HANDSHAKE_LINE <= 1'b0;
    end else begin
      O_HANDSHAKE_LINE <= (state_q == S_RX && !frame_done)
                          || ((state_q == S_SEND || state_q == S_DRAIN) && tx_loaded_q);
    end
  end

  // serial out from its own flop, loaded with the same next value as the shifter msb
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) O_LINK_SO <= 1'b1;
    else O_LINK_SO <= (byte_done || pop) ? (buf_valid ? buf_data[7] : 1'b1)
                      : ((fall && bitcnt_q != 3'h0) ? txsh_q[6] : txsh_q[7]);
  end

  // =========================================================
  // checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);

  sequence eval_seen;
    state_q == S_EVAL;
  endsequence
  sequence status_out(logic [7:0] c);
    state_q == S_SEND && pay_q[23:16] == c && plen_q == STAT_PLEN;
  endsequence

  a_ack_status: assert property ((state_q == S_EVAL && !bad_q && acc_q == 8'h00 && frm.cmd == CMD_VERSION
      && len_q == LEN_VERSION) |=> status_out(ST_ACK) ##0 data_next_q) else $error("ack status not sent");
  a_sum_status: assert property ((state_q == S_EVAL && !bad_q && acc_q != 8'h00 && frm.cmd == CMD_VERSION
      && len_q == LEN_VERSION) |=> status_out(ST_SUM_ERR) ##0 !data_next_q) else $error("sum error not sent");
  a_nack_len: assert property ((byte_done && state_q == S_RX && rcnt_q == 4'h1 && rx_byte > LEN_MAX)
      |=> eval_seen ##1 status_out(ST_NACK)) else $error("nack not sent for bad length");
  a_param_status: assert property ((state_q == S_EVAL && !bad_q && acc_q == 8'h00 && frm.cmd == CMD_CHECKSUM
      && len_q == LEN_CHECKSUM && frm.start[BLOCK_BITS-1:0] != '0) |=> status_out(ST_PARAM_ERR))
      else $error("param error not sent");
  a_busy_hold: assert property ((state_q == S_EVAL || state_q == S_CALC) |=> !O_HANDSHAKE_LINE)
      else $error("handshake ready while processing");
  a_busy_frame: assert property ($rose(state_q == S_EVAL) |-> ##1 !O_HANDSHAKE_LINE [*2])
      else $error("handshake not busy after frame");
endmodule

/* File: logic/fvc_pkg.sv */
package fvc_pkg;
  // =========================================================
  // frame framing bytes
  localparam logic [7:0] SOH_BYTE = 8'h01;
  localparam logic [7:0] STX_BYTE = 8'h02;
  localparam logic [7:0] ETX_BYTE = 8'h03;
  localparam logic [7:0] IDLE_FILL = 8'hff;
  // =========================================================
  // status codes
  localparam logic [7:0] ST_ACK = 8'h06;
  localparam logic [7:0] ST_SUM_ERR = 8'h07;
  localparam logic [7:0] ST_NACK = 8'h15;
  localparam logic [7:0] ST_PARAM_ERR = 8'h05;
  // =========================================================
  // command codes and frame_length_field values
  localparam logic [7:0] CMD_VERSION = 8'hc5;
  localparam logic [7:0] CMD_CHECKSUM = 8'hb0;
  localparam logic [7:0] LEN_VERSION = 8'h01;
  localparam logic [7:0] LEN_CHECKSUM = 8'h07;
  localparam logic [7:0] LEN_MAX = 8'h07;
  localparam logic [7:0] STAT_PLEN = 8'h01;
  localparam logic [7:0] VER_PLEN = 8'h03;
  localparam logic [7:0] SUM_PLEN = 8'h02;
  // =========================================================
  // flash geometry
  localparam int ADDR_W = 24;
  localparam int BLOCK_BITS = 11;
  localparam int BLOCK_BYTES = 2048;
  localparam logic [23:0] FLASH_BYTES_DEF = 24'h040000;
  localparam logic [23:0] VERSION_DEF = 24'h010203;
  localparam int BUF_DEPTH = 2;

  // parsed command frame body
  typedef struct packed {
    logic [7:0] cmd;
    logic [23:0] start;
    logic [23:0] stop;
  } cmd_frame_s;
endpackage

/* File: logic/byte_buf.sv */
`timescale 1ns/100ps
module byte_buf #(
  parameter int W = 8,
  parameter int D = 2
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_data,
  input wire logic i_valid,
  output logic o_ready,
  output logic [W-1:0] o_data,
  output logic o_valid,
  input wire logic i_ready
);
  localparam int PW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0] mem_q [D];
  logic [PW-1:0] wp_q;
  logic [PW-1:0] rp_q;
  logic [PW:0] cnt_q;
  logic push;
  logic pop;

  // honest flags straight from the count
  assign o_ready = (cnt_q < (PW+1)'(D));
  assign o_valid = (cnt_q != '0);
  assign o_data = mem_q[rp_q];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  // storage written only on accept
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wp_q] <= i_data;
    end
  end

  // pointers wrap at depth
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == PW'(D-1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == PW'(D-1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

/* File: sim/prog_model.sv */
`timescale 1ns/100ps
// =========================================
// programmer end of the serial link
module prog_model (
  // link towards the device
  output logic o_sck,
  output logic o_si,
  input wire logic i_so,
  input wire logic i_hs
);
  // link clock stands still high between bytes
  initial begin
    o_sck = 1'b1;
    o_si = 1'b1;
  end

  // one byte each way, msb first; random gap lets the device see a slow partner
  // gap never zero, so the data line is not set twice in one step
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    #($urandom_range(1, 600));
    for (int i = 7; i >= 0; i--) begin
      o_sck <= 1'b0;
      o_si <= tx[i];
      #160;
      o_sck <= 1'b1;
      rx[i] = i_so;
      #160;
    end
    o_si <= ~tx[0]; // no stale level once the byte is over
  endtask

  // bounded wait for ready; ok stays low when the wait times out
  task automatic wait_hs(input int lim, output logic ok);
    ok = 1'b0;
    for (int n = 0; n < lim && !ok; n++) begin
      #40;
      ok = (i_hs === 1'b1);
    end
  endtask
endmodule

/* File: sim/tb_top.sv */
`timescale 1ns/100ps
module tb_top
  import fvc_pkg::*;
;
  // =========================================
  // clock, reset and wiring
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic sck, si, so, handshake_line;
  logic [23:0] faddr;
  logic [7:0] fdata = 8'h00;
  int errors = 0;
  int compares = 0;

  always #20 clk = ~clk;

  flash_cmd_dev u_dut (
    .I_CLK(clk), .I_RSTN(rstn), .I_LINK_SCK(sck), .I_LINK_SI(si), .O_LINK_SO(so),
    .O_HANDSHAKE_LINE(handshake_line), .O_FLASH_ADDR(faddr), .I_FLASH_RDATA(fdata)
  );

  prog_model u_prog (.o_sck(sck), .o_si(si), .i_so(so), .i_hs(handshake_line));

  // =========================================
  // flash pattern, one clock read latency
  function automatic logic [7:0] fmem(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction

  always @(posedge clk) fdata <= fmem(faddr);

  // expected result: 16-bit two's complement of the byte sum
  function automatic logic [15:0] sum_of(input logic [23:0] a, input logic [23:0] e);
    logic [15:0] s;
    s = 16'h0000;
    for (int i = int'(a); i <= int'(e); i++) s -= 16'(fmem(24'(i)));
    return s;
  endfunction

  // =========================================
  // checking and closing
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // a wait that runs out ends the run at once
  task automatic wait_ready(input int lim);
    logic ok;
    u_prog.wait_hs(lim, ok);
    check({31'h0, ok}, 32'h1);
    if (ok !== 1'b1) results();
  endtask

  // =========================================
  // frame level helpers
  task automatic recv(input int n, output logic [7:0] r[$]);
    logic [7:0] b;
    r = {};
    repeat (n) begin
      wait_ready(20000);
      u_prog.xfer(8'hff, b);
      r.push_back(b);
    end
  endtask

  // sadj skews the frame sum; bad length frames stop after the length byte
  task automatic cmd(input logic [7:0] len, input logic [7:0] op, input logic [47:0] prm,
                     input logic [7:0] sadj, input logic [7:0] etx, input logic [7:0] exp);
    logic [7:0] q[$];
    logic [7:0] r[$];
    logic [7:0] s;
    logic [7:0] b;
    q = {SOH_BYTE, len, op};
    s = len + op;
    for (int i = 0; i < int'(len) - 1 && i < 6; i++) begin
      q.push_back(prm[47 - 8 * i -: 8]);
      s += prm[47 - 8 * i -: 8];
    end
    q.push_back(sadj - s);
    q.push_back(etx);
    if (len == 8'h00 || len > LEN_MAX) q = q[0:1];
    wait_ready(200);
    foreach (q[i]) u_prog.xfer(q[i], b);
    recv(5, r);
    check({r[0], r[1], r[2], r[4]}, {STX_BYTE, STAT_PLEN, exp, ETX_BYTE});
    check({24'h000000, 8'(r[1] + r[2] + r[3])}, 32'h0);
  endtask

  task automatic data(input int len, output logic [7:0] p[$]);
    logic [7:0] r[$];
    logic [7:0] s;
    recv(len + 4, r);
    s = 8'h00;
    for (int i = 1; i <= len + 2; i++) s += r[i];
    check({r[0], r[1], r[len + 3], s}, {STX_BYTE, 8'(len), ETX_BYTE, 8'h00});
    p = r[2:len + 1];
  endtask

  // =========================================
  // main sequence
  initial begin
    logic [7:0] p[$];
    logic [23:0] a;
    logic [23:0] e;
    logic ok;
    logic [47:0] bad [4];
    void'($urandom(89786));
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    // version read, then each kind of broken frame
    cmd(LEN_VERSION, CMD_VERSION, 48'h0, 8'h00, ETX_BYTE, ST_ACK);
    data(3, p);
    check({8'h00, p[0], p[1], p[2]}, {8'h00, VERSION_DEF});
    cmd(LEN_VERSION, CMD_VERSION, 48'h0, 8'h01, ETX_BYTE, ST_SUM_ERR);
    cmd(LEN_VERSION, CMD_VERSION, 48'h0, 8'h00, 8'h04, ST_NACK);
    cmd(8'h00, CMD_VERSION, 48'h0, 8'h00, ETX_BYTE, ST_NACK);
    cmd(8'h08, CMD_VERSION, 48'h0, 8'h00, ETX_BYTE, ST_NACK);
    cmd(LEN_CHECKSUM, CMD_VERSION, 48'h0, 8'h00, ETX_BYTE, ST_NACK);
    cmd(LEN_VERSION, 8'h11, 48'h0, 8'h00, ETX_BYTE, ST_NACK);
    cmd(LEN_CHECKSUM, CMD_CHECKSUM, 48'h0007ff, 8'h01, ETX_BYTE, ST_SUM_ERR);
    // ranges off the 2 KB grid, with stop below start, or past the end of flash
    bad = '{{24'h000001, 24'h0007ff}, {24'h000000, 24'h0007fe}, {24'h001000, 24'h0007ff},
            {FLASH_BYTES_DEF, FLASH_BYTES_DEF + 24'h0007ff}};
    foreach (bad[i]) cmd(LEN_CHECKSUM, CMD_CHECKSUM, bad[i], 8'h00, ETX_BYTE, ST_PARAM_ERR);
    // last block first, then random one and two block ranges
    for (int k = 0; k < 3; k++) begin
      a = (k == 0) ? 24'h03f800 : 24'($urandom_range(0, 126)) << BLOCK_BITS;
      e = a + 24'(BLOCK_BYTES * (1 + k % 2)) - 24'h000001;
      cmd(LEN_CHECKSUM, CMD_CHECKSUM, {a, e}, 8'h00, ETX_BYTE, ST_ACK);
      #400;
      check({31'h0, handshake_line}, 32'h0);
      u_prog.wait_hs(10, ok);
      check({31'h0, ok}, 32'h0);
      data(2, p);
      check({16'h0000, p[0], p[1]}, {16'h0000, sum_of(a, e)});
    end
    results();
  end
endmodule
